//--- rtl/cltd_detector.sv
// channel 0 level trigger detector with ahb-lite register slave
// assumes samples arrive on hclk with a one-cycle sample_valid strobe
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cltd_detector
	import cltd_pkg::*;
#(
	parameter int CNT_W = PLEN_W
)(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic                sample_valid,
	input  wire logic [LEVEL_W-1:0]  sample_data,
	output logic                     trig_event,
	output logic                     irq
);
	logic        [31:0]        src_q, src_d, mode_q, mode_d;
	logic signed [LEVEL_W-1:0] upper_q, upper_d, lower_q, lower_d;
	logic        [CNT_W-1:0]   plen_q, plen_d;
	logic        [IRQ_W-1:0]   istat_q, istat_d, ien_q, ien_d;
	logic        [31:0]        hrdata_q, hrdata_d;
	logic                      wr_q, wr_d;
	logic        [15:0]        addr_q, addr_d;
	logic                      cfg_wr;
	logic signed [LEVEL_W-1:0] smp, prev_q, prev_d;
	logic                      have_q, have_d;
	cltd_state_t               state_q, state_d;
	logic        [CNT_W-1:0]   cnt_q, cnt_d, cnt_inc;
	logic                      trig_q, trig_d, drop_q, drop_d;
	logic                      src_ok, run;
	logic                      rise_u, fall_u, rise_l, reach_u;
	logic                      start, stop, stop_fire, exp_fire, edge_fire;

	// saturate a written level so the most negative code never appears
	function automatic logic signed [LEVEL_W-1:0] clamp_level(
		input logic [31:0] w
	);
		logic signed [31:0] v;
		v = $signed(w);
		if (v > LEVEL_MAX)
			clamp_level = LEVEL_MAX[LEVEL_W-1:0];
		else if (v < LEVEL_MIN)
			clamp_level = LEVEL_MIN[LEVEL_W-1:0];
		else
			clamp_level = v[LEVEL_W-1:0];
	endfunction

	// zero-wait slave, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign trig_event = trig_q;
	assign irq        = |(istat_q & ien_q);
	// mode or source changes abandon any measurement in flight
	assign cfg_wr = wr_q & ((addr_q == ADDR_MODE) | (addr_q == ADDR_SRC));

	// register file; reads other than ADDR_DET_STAT use next values so a read right after a write
	// of the same register already sees the new data
	always_comb
	begin
		wr_d     = 1'b0;
		addr_d   = addr_q;
		src_d    = src_q;
		mode_d   = mode_q;
		upper_d  = upper_q;
		lower_d  = lower_q;
		plen_d   = plen_q;
		ien_d    = ien_q;
		istat_d  = istat_q;
		hrdata_d = hrdata_q;
		if (wr_q)
		begin
			case (addr_q)
				ADDR_SRC:     src_d   = hwdata;
				ADDR_MODE:    mode_d  = hwdata;
				ADDR_UPPER:   upper_d = clamp_level(hwdata);
				ADDR_LOWER:   lower_d = clamp_level(hwdata);
				ADDR_PLEN:    plen_d  = hwdata[CNT_W-1:0];
				ADDR_IRQ_EN:  ien_d   = hwdata[IRQ_W-1:0];
				ADDR_IRQ_CLR: istat_d = istat_q & ~hwdata[IRQ_W-1:0];
				default:      istat_d = istat_q;
			endcase
		end
		// a new event in the clearing cycle survives the clear
		istat_d[IRQ_TRIG_BIT] = istat_d[IRQ_TRIG_BIT] | trig_q;
		istat_d[IRQ_DROP_BIT] = istat_d[IRQ_DROP_BIT] | drop_q;
		if (hready)
		begin
			hrdata_d = 32'h0000_0000;
			if (hsel & htrans[1])
			begin
				addr_d = (haddr[31:16] == 16'h0000) ? haddr[15:0]
					: ADDR_NONE;
				// sub-word writes are ignored
				wr_d = hwrite & (hsize == HSIZE_WORD);
				if (!hwrite)
				begin
					case (addr_d)
						ADDR_SRC:      hrdata_d = src_d;
						ADDR_MODE:     hrdata_d = mode_d;
						ADDR_UPPER:    hrdata_d = 32'(upper_d);
						ADDR_LOWER:    hrdata_d = 32'(lower_d);
						ADDR_PLEN:     hrdata_d = 32'(plen_d);
						ADDR_IRQ_STAT: hrdata_d = 32'(istat_d);
						ADDR_IRQ_EN:   hrdata_d = 32'(ien_d);
						// sized on purpose so a wider counter still fits
						ADDR_DET_STAT: hrdata_d = 32'({cnt_q, state_q,
							have_q});
						default:       hrdata_d = 32'h0000_0000;
					endcase
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q     <= 1'b0;
			addr_q   <= 16'h0000;
			src_q    <= SRC_RESET;
			mode_q   <= MODE_RESET;
			upper_q  <= '0;
			lower_q  <= '0;
			plen_q   <= CNT_W'(PLEN_RESET);
			ien_q    <= '0;
			istat_q  <= '0;
			hrdata_q <= 32'h0000_0000;
		end
		else
		begin
			wr_q     <= wr_d;
			addr_q   <= addr_d;
			src_q    <= src_d;
			mode_q   <= mode_d;
			upper_q  <= upper_d;
			lower_q  <= lower_d;
			plen_q   <= plen_d;
			ien_q    <= ien_d;
			istat_q  <= istat_d;
			hrdata_q <= hrdata_d;
		end
	end

	// crossing detection against the previous accepted sample
	assign smp     = $signed(sample_data);
	assign src_ok  = (src_q == SRC_CHANNEL);
	assign run     = sample_valid & src_ok & have_q & ~cfg_wr;
	assign rise_u  = (prev_q < upper_q) & (smp >= upper_q);
	assign fall_u  = (prev_q >= upper_q) & (smp < upper_q);
	assign rise_l  = (prev_q < lower_q) & (smp >= lower_q);
	assign reach_u = (smp >= upper_q);
	assign cnt_inc = cnt_q + CNT_W'(1);

	// detector: the mode picks start/stop events, one counter serves all
	always_comb
	begin
		start     = 1'b0;
		stop      = 1'b0;
		stop_fire = 1'b0;
		exp_fire  = 1'b0;
		edge_fire = 1'b0;
		state_d   = state_q;
		cnt_d     = cnt_q;
		trig_d    = 1'b0;
		drop_d    = 1'b0;
		prev_d    = prev_q;
		have_d    = have_q;
		case (mode_q)
			MODE_BOTH:      edge_fire = rise_u | fall_u;
			MODE_LONG_POS:
			begin
				start    = rise_u;
				stop     = fall_u;
				exp_fire = 1'b1;
			end
			MODE_LONG_NEG:
			begin
				start    = fall_u;
				stop     = rise_u;
				exp_fire = 1'b1;
			end
			MODE_SHORT_POS:
			begin
				start     = rise_u;
				stop      = fall_u;
				stop_fire = 1'b1;
			end
			MODE_SHORT_NEG:
			begin
				start     = fall_u;
				stop      = rise_u;
				stop_fire = 1'b1;
			end
			MODE_FLAT_POS:
			begin
				// a jump past both levels in one sample is already too steep
				start    = rise_l & ~reach_u;
				stop     = reach_u;
				exp_fire = 1'b1;
			end
			default:        start = 1'b0;
		endcase
		if (sample_valid & src_ok)
		begin
			prev_d = smp;
			have_d = 1'b1;
		end
		if (!src_ok | cfg_wr)
		begin
			state_d = ST_IDLE;
			cnt_d   = '0;
			have_d  = 1'b0;
		end
		else if (run)
		begin
			case (state_q)
				ST_IDLE:
				begin
					trig_d = edge_fire;
					if (start)
					begin
						state_d = ST_COUNT;
						cnt_d   = '0;
					end
				end
				ST_COUNT:
				begin
					// a crossing on the expiry sample takes priority
					if (stop)
					begin
						state_d = ST_IDLE;
						cnt_d   = '0;
						trig_d  = stop_fire;
						drop_d  = ~stop_fire;
					end
					else if (cnt_inc == plen_q)
					begin
						state_d = ST_IDLE;
						cnt_d   = '0;
						trig_d  = exp_fire;
						drop_d  = ~exp_fire;
					end
					else
						cnt_d = cnt_inc;
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			trig_q  <= 1'b0;
			drop_q  <= 1'b0;
			prev_q  <= '0;
			have_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			trig_q  <= trig_d;
			drop_q  <= drop_d;
			prev_q  <= prev_d;
			have_q  <= have_d;
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic live, side_chg, longm, shortm;
	assign live     = sample_valid & src_ok & have_q & ~cfg_wr;
	assign side_chg = (prev_q < upper_q) != (smp < upper_q);
	assign longm    = (mode_q == MODE_LONG_POS) | (mode_q == MODE_LONG_NEG);
	assign shortm   = (mode_q == MODE_SHORT_POS) | (mode_q == MODE_SHORT_NEG);

	chk_source_gate: assert property (
		!src_ok ##1 !src_ok |-> !trig_event)
		else $error("trigger while source not channel");
	chk_both_edge: assert property (
		live && mode_q == MODE_BOTH && side_chg |=> trig_event)
		else $error("both-edge crossing missed");
	chk_long_start: assert property (
		live && state_q == ST_IDLE && mode_q == MODE_LONG_POS
		&& prev_q < upper_q && smp >= upper_q |=> state_q == ST_COUNT)
		else $error("long pulse did not start");
	chk_long_cancel: assert property (
		live && state_q == ST_COUNT && longm && side_chg
		|=> !trig_event && state_q == ST_IDLE)
		else $error("long pulse cancel fired");
	chk_long_expire: assert property (
		live && state_q == ST_COUNT && longm && !side_chg
		&& cnt_q == plen_q - CNT_W'(1) |=> trig_event)
		else $error("long pulse expiry missed");
	chk_short_expire: assert property (
		live && state_q == ST_COUNT && shortm && !side_chg
		&& cnt_q == plen_q - CNT_W'(1) |=> !trig_event ##1 !trig_event)
		else $error("short pulse expiry fired");
	chk_short_return: assert property (
		live && state_q == ST_COUNT && shortm && side_chg |=> trig_event)
		else $error("short pulse return missed");
	chk_flat_steep: assert property (
		live && state_q == ST_COUNT && mode_q == MODE_FLAT_POS
		&& smp >= upper_q |=> !trig_event && state_q == ST_IDLE)
		else $error("steep slope fired");
	chk_level_range: assert property (
		upper_q != 6'h20 && lower_q != 6'h20)
		else $error("level holds most negative code");
	chk_count_step: assert property (
		live && state_q == ST_COUNT && $past(state_q) == ST_COUNT
		|-> cnt_q != '0 || $past(cnt_q) == '0)
		else $error("counter lost its place");

	cov_both_fire: cover property (mode_q == MODE_BOTH && trig_event);
	cov_long_fire: cover property (longm && trig_event);
	cov_short_fire: cover property (shortm && trig_event);
	cov_flat_fire: cover property (mode_q == MODE_FLAT_POS && trig_event);
endmodule

//--- rtl/cltd_pkg.sv
// constants and types of the channel level trigger detector
// assumes a 32-bit ahb-lite register bus and 6-bit signed samples
package cltd_pkg;
	// register byte addresses
	localparam logic [15:0] ADDR_SRC      = 16'h9C40;
	localparam logic [15:0] ADDR_MODE     = 16'h9D08;
	localparam logic [15:0] ADDR_UPPER    = 16'hA410;
	localparam logic [15:0] ADDR_LOWER    = 16'hA474;
	localparam logic [15:0] ADDR_PLEN     = 16'hABE0;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hB000;
	localparam logic [15:0] ADDR_IRQ_CLR  = 16'hB004;
	localparam logic [15:0] ADDR_IRQ_EN   = 16'hB008;
	localparam logic [15:0] ADDR_DET_STAT = 16'hB00C;
	localparam logic [15:0] ADDR_NONE     = 16'hFFFF;

	// source and mode codes
	localparam logic [31:0] SRC_CHANNEL     = 32'h0000_4E48;
	localparam logic [31:0] MODE_BOTH       = 32'h0000_272E;
	localparam logic [31:0] MODE_LONG_POS   = 32'h0000_2711;
	localparam logic [31:0] MODE_LONG_NEG   = 32'h0000_271B;
	localparam logic [31:0] MODE_SHORT_POS  = 32'h0000_2712;
	localparam logic [31:0] MODE_SHORT_NEG  = 32'h0000_271C;
	localparam logic [31:0] MODE_FLAT_POS   = 32'h0000_2713;

	// level format and limits
	localparam int                 LEVEL_W   = 6;
	localparam logic signed [31:0] LEVEL_MAX = 32'sh0000_001F;
	localparam logic signed [31:0] LEVEL_MIN = -32'sh0000_001F;

	// pulse length and reset values
	localparam int          PLEN_W     = 8;
	localparam logic [31:0] SRC_RESET  = 32'h0000_0000;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [7:0]  PLEN_RESET = 8'h02;

	// interrupt status layout
	localparam int IRQ_W        = 2;
	localparam int IRQ_TRIG_BIT = 0;
	localparam int IRQ_DROP_BIT = 1;

	// ahb encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_COUNT = 1'b1
	} cltd_state_t;
endpackage

//--- verif/cltd_sample_src.sv
// converter model: hands one signed sample per call to the detector
// assumes the caller sits just after a rising hclk edge
`timescale 1ns/1ps
module cltd_sample_src
	import cltd_pkg::*;
(
	input  wire logic               hclk,
	output logic                    sample_valid,
	output logic [LEVEL_W-1:0]      sample_data
);
	initial
	begin
		sample_valid = 1'h0;
		sample_data  = '0;
	end

	// between samples the lines show the inverse of the last value, so a
	// stale sample can never pass for a fresh one
	task automatic send(input logic [LEVEL_W-1:0] v);
		sample_valid <= 1'h1;
		sample_data  <= v;
		@(posedge hclk);
		sample_valid <= 1'h0;
		sample_data  <= ~v;
		@(posedge hclk);
	endtask
endmodule

//--- verif/testbench.sv
// self-checking bench of the channel level trigger detector
// assumes the detector answers each ahb-lite phase within the 50-cycle hready poll bound
`timescale 1ns/1ps
module testbench
	import cltd_pkg::*;
;
	logic               hclk;
	logic               hresetn;
	logic               hsel;
	logic [31:0]        haddr;
	logic [1:0]         htrans;
	logic               hwrite;
	logic [2:0]         hsize;
	logic [31:0]        hwdata;
	logic [31:0]        hrdata;
	logic               hreadyout;
	logic               hresp;
	logic               sample_valid;
	logic [LEVEL_W-1:0] sample_data;
	logic               trig_event;
	logic               irq;
	int                 n_mismatch;
	int                 num_checks;
	int                 n_trig = 0;

	cltd_detector cltd_detector_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.trig_event(trig_event), .irq(irq));

	cltd_sample_src cltd_sample_src_i (.hclk(hclk),
		.sample_valid(sample_valid), .sample_data(sample_data));

	initial
	begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end

	// trigger pulses are counted per scenario
	always @(posedge hclk)
		if (trig_event === 1'h1)
			n_trig++;

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// the master never assumes a latency: it polls hready, bounded
	task automatic wait_rdy();
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1 && i < 50)
		begin
			@(posedge hclk);
			i++;
		end
		if (i == 50)
		begin
			n_mismatch++;
			close_out();
		end
	endtask

	task automatic bus(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'h1;
		haddr  <= {16'h0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, r);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'h0, a, 32'h0, r);
		chk(r, exp);
	endtask

	task automatic irq_is(input logic exp);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	// program one measurement, play the samples, count the triggers
	task automatic run(input logic [31:0] src, input logic [31:0] mode,
		input int up, input int lo, input int s[$], input int exp);
		int base;
		wr(ADDR_UPPER, 32'(up));
		wr(ADDR_LOWER, 32'(lo));
		wr(ADDR_PLEN, 32'h3);
		wr(ADDR_SRC, src);
		wr(ADDR_MODE, mode);
		// only the counting process writes n_trig; a scenario takes the difference
		base = n_trig;
		foreach (s[i])
			cltd_sample_src_i.send(6'(s[i]));
		repeat (3) @(posedge hclk);
		chk(32'(n_trig - base), 32'(exp));
	endtask

	task automatic t_reset();
		chk({31'h0, hresp}, 32'h0);
		rd(ADDR_SRC, SRC_RESET);
		rd(ADDR_MODE, MODE_RESET);
		rd(ADDR_PLEN, {24'h0, PLEN_RESET});
		rd(ADDR_UPPER, 32'h0);
		rd(ADDR_IRQ_STAT, 32'h0);
		rd(ADDR_DET_STAT, 32'h0);
		wr(ADDR_NONE, 32'h5A5A_5A5A);
		rd(ADDR_NONE, 32'h0);
	endtask

	// out-of-range levels saturate and read back sign-extended
	task automatic t_levels();
		wr(ADDR_UPPER, 32'h0000_0020);
		rd(ADDR_UPPER, LEVEL_MAX);
		// a byte-sized write must leave the register alone
		hsize <= 3'h0;
		wr(ADDR_UPPER, 32'h0000_0003);
		hsize <= HSIZE_WORD;
		rd(ADDR_UPPER, LEVEL_MAX);
		wr(ADDR_LOWER, 32'hFFFF_FFD8);
		rd(ADDR_LOWER, LEVEL_MIN);
	endtask

	task automatic t_modes();
		run(SRC_RESET, MODE_BOTH, 5, 0, '{0, 6, 4, 6}, 0);
		run(SRC_CHANNEL, MODE_BOTH, 5, 0, '{0, 6, 6, 4, 4, 5}, 3);
		run(SRC_CHANNEL, MODE_LONG_POS, 5, 0,
			'{0, 6, 6, 6, 6, 4, 6, 6, 6, 6}, 2);
		run(SRC_CHANNEL, MODE_LONG_POS, 5, 0, '{0, 6, 6, 4, 4}, 0);
		run(SRC_CHANNEL, MODE_LONG_NEG, 5, 0, '{6, 4, 4, 4, 4}, 1);
		run(SRC_CHANNEL, MODE_SHORT_POS, 5, 0, '{0, 6, 6, 4}, 1);
		run(SRC_CHANNEL, MODE_SHORT_POS, 5, 0,
			'{0, 6, 6, 6, 6, 4}, 0);
		run(SRC_CHANNEL, MODE_SHORT_NEG, 5, 0, '{6, 4, 4, 6}, 1);
		run(SRC_CHANNEL, MODE_FLAT_POS, 5, -5,
			'{-8, 0, 0, 0, 0}, 1);
		run(SRC_CHANNEL, MODE_FLAT_POS, 5, -5, '{-8, 0, 6, 0, 0}, 0);
	endtask

	// status is sticky, masked by enable, cleared by writing ones
	task automatic t_irq();
		wr(ADDR_IRQ_EN, 32'h1);
		irq_is(1'h1);
		wr(ADDR_IRQ_EN, 32'h0);
		irq_is(1'h0);
		wr(ADDR_IRQ_CLR, 32'h3);
		rd(ADDR_IRQ_STAT, 32'h0);
		rd(ADDR_IRQ_CLR, 32'h0);
		wr(ADDR_IRQ_EN, 32'h1);
		irq_is(1'h0);
		run(SRC_CHANNEL, MODE_LONG_POS, 5, 0, '{0, 6, 6, 6, 6}, 1);
		irq_is(1'h1);
		rd(ADDR_IRQ_STAT, 32'h1);
		wr(ADDR_IRQ_CLR, 32'h1);
		irq_is(1'h0);
	endtask

	// reset in mid-run returns programmed registers to their reset values
	task automatic t_rereset();
		wr(ADDR_IRQ_EN, 32'h3);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, trig_event}, 32'h0);
		chk(hrdata, 32'h0);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(ADDR_MODE, MODE_RESET);
		rd(ADDR_SRC, SRC_RESET);
		rd(ADDR_IRQ_EN, 32'h0);
		rd(ADDR_DET_STAT, 32'h0);
	endtask

	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_reset();
		t_levels();
		t_modes();
		t_irq();
		t_rereset();
		close_out();
	end
endmodule
